// ---- rtl/floppy_ctl_pkg.sv ----
// Constants shared by the floppy control-command unit.
package floppy_ctl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_UNIT_NS = 500000;
  localparam int UNIT_CYCLES = (STEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_SPEC = 8'h04;
  localparam logic [7:0] OFF_CONF = 8'h08;
  localparam logic [7:0] OFF_RESULT = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_ID = 8'h14;
  localparam logic [3:0] OP_SEEK = 4'h1;
  localparam logic [3:0] OP_RECAL = 4'h2;
  localparam logic [3:0] OP_READ_ID = 4'h3;
  localparam logic [3:0] OP_SENSE_INT = 4'h4;
  localparam logic [3:0] OP_SENSE_DRIVE = 4'h5;
  localparam logic [2:0] RATE_1M = 3'h0;
  localparam logic [2:0] RATE_2M = 3'h1;
  localparam logic [2:0] RATE_500K = 3'h2;
  localparam logic [2:0] RATE_300K = 3'h3;
  localparam logic [2:0] RATE_250K = 3'h4;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_POLL = 2'h3;
  localparam logic [6:0] RECAL_MAX_STEPS = 7'h4f;
  localparam logic [8:0] STEP_SPAN_UNITS = 9'h010;
  localparam logic [8:0] FULL_UNITS = 9'h100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic FIFO_DISABLE_RST = 1'b1;
  localparam logic [3:0] FIFO_LEVEL_RST = 4'h0;
  localparam logic [7:0] PRECOMP_RST = 8'h00;
endpackage

// ---- rtl/drive_delay_timer.sv ----
// Delay timer counting whole units of a scaled prescale period.
`timescale 1ns/10ps
`default_nettype none
module drive_delay_timer (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [8:0] units_in,
  input wire logic [31:0] unit_cycles_in,
  output logic done_out,
  output logic running_out
);
  typedef struct packed {
    logic running;
    logic done;
    logic [31:0] pre;
    logic [8:0] left;
  } timer_type;

  timer_type s_reg;
  timer_type s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start_in) begin
      s_next.running = 1'b1;
      s_next.pre = 32'h0000_0000;
      s_next.left = units_in;
    end else if (s_reg.running) begin
      if (s_reg.pre >= unit_cycles_in - 32'h0000_0001) begin
        s_next.pre = 32'h0000_0000;
        if (s_reg.left <= 9'h001) begin
          s_next.running = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.left = s_reg.left - 9'h001;
        end
      end else begin
        s_next.pre = s_reg.pre + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_out = s_reg.done;
  assign running_out = s_reg.running;
endmodule
`default_nettype wire

// ---- rtl/floppy_control_commands.sv ----
// Control-command unit of a floppy controller with an AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
module floppy_control_commands #(
  parameter int UNIT_CYCLES = floppy_ctl_pkg::UNIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [7:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [7:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  input wire logic index_pulse_in,
  input wire logic track_zero_in,
  input wire logic id_found_in,
  input wire logic [31:0] id_field_in,
  input wire logic [7:0] drive_status_in,
  input wire logic result_entry_in,
  input wire logic xfer_need_in,
  input wire logic rw_exec_end_in,
  input wire logic head_load_in,
  input wire logic powerdown_exit_in,
  output logic step_out,
  output logic step_way_out,
  output logic interrupt_out,
  output logic request_for_master_out,
  output logic dma_request_out,
  output logic head_unloaded_out,
  output logic head_ready_out,
  output logic implied_seek_enable_out,
  output logic fifo_disable_out,
  output logic [4:0] fifo_threshold_out,
  output logic [7:0] precomp_start_cylinder_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD = 3'b001,
    ST_CHECK = 3'b010,
    ST_PULSE = 3'b011,
    ST_WAIT = 3'b100,
    ST_READ_ID = 3'b101
  } fsm_type;

  typedef struct packed {
    fsm_type fsm;
    logic busy;
    logic aw_ok;
    logic w_ok;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] op;
    logic [1:0] drv;
    logic [15:0] spec;
    logic [18:0] conf;
    logic [7:0] present_cylinder;
    logic [7:0] new_cylinder;
    logic [7:0] st0;
    logic ma;
    logic [7:0] st3;
    logic [31:0] id_field;
    logic intr;
    logic [3:0] drive_busy;
    logic poll_pending;
    logic [6:0] steps;
    logic [1:0] idx_cnt;
    logic idx_prev;
    logic load_prev;
    logic step;
    logic step_way;
    logic t_start;
  } state_type;

  state_type s_reg;
  state_type s_next;
  logic step_done;
  logic hut_run;
  logic hlt_run;
  logic [31:0] unit_cyc;
  logic idx_edge;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rate_cycles(input logic [2:0] rate);
    logic [31:0] base;
    base = 32'(UNIT_CYCLES);
    case (rate)
      floppy_ctl_pkg::RATE_2M: rate_cycles = base >> 1;
      floppy_ctl_pkg::RATE_500K: rate_cycles = base << 1;
      floppy_ctl_pkg::RATE_300K: rate_cycles = 32'((64'(base) * 64'd10) / 64'd3);
      floppy_ctl_pkg::RATE_250K: rate_cycles = base << 2;
      default: rate_cycles = base;
    endcase
  endfunction

  function automatic logic [7:0] make_st0(input logic [1:0] ic, input logic se,
                                          input logic ec, input logic [1:0] drv);
    make_st0 = {ic, se, ec, 1'b0, 1'b0, drv};
  endfunction

  assign unit_cyc = rate_cycles(s_reg.conf[18:16]);
  assign idx_edge = index_pulse_in && !s_reg.idx_prev;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [31:0] w;
    logic [3:0] op;
    w = s_reg.wdata;
    op = w[3:0];
    s_next = s_reg;
    s_next.t_start = 1'b0;
    s_next.idx_prev = index_pulse_in;
    s_next.load_prev = head_load_in;
    if (s_reg.bvalid && bready_in) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && rready_in) begin
      s_next.rvalid = 1'b0;
    end
    if (awvalid_in && !s_reg.aw_ok && !s_reg.bvalid) begin
      s_next.aw_ok = 1'b1;
      s_next.waddr = awaddr_in;
    end
    if (wvalid_in && !s_reg.w_ok && !s_reg.bvalid) begin
      s_next.w_ok = 1'b1;
      s_next.wdata = wdata_in;
      s_next.wstrb = wstrb_in;
    end
    if (powerdown_exit_in) begin
      s_next.present_cylinder = 8'h00;
      s_next.st0 = 8'h00;
      s_next.ma = 1'b0;
    end
    if (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid) begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = floppy_ctl_pkg::RESP_OKAY;
      case (s_reg.waddr)
        floppy_ctl_pkg::OFF_SPEC: begin
          s_next.spec = 16'(merge({16'h0000, s_reg.spec}, w, s_reg.wstrb));
        end
        floppy_ctl_pkg::OFF_CONF: begin
          s_next.conf = 19'(merge({13'h0000, s_reg.conf}, w, s_reg.wstrb));
        end
        floppy_ctl_pkg::OFF_CMD: begin
          if (op == floppy_ctl_pkg::OP_SENSE_INT) begin
            s_next.intr = 1'b0;
            s_next.drive_busy[s_reg.drv] = 1'b0;
          end else if (op == floppy_ctl_pkg::OP_SENSE_DRIVE) begin
            s_next.st3 = drive_status_in;
          end else if ((op == floppy_ctl_pkg::OP_SEEK || op == floppy_ctl_pkg::OP_RECAL ||
                        op == floppy_ctl_pkg::OP_READ_ID) && s_reg.fsm == ST_IDLE) begin
            s_next.fsm = ST_CMD;
            s_next.busy = 1'b1;
            s_next.op = op;
            s_next.drv = w[5:4];
            s_next.new_cylinder = w[15:8];
            if (op != floppy_ctl_pkg::OP_READ_ID) begin
              s_next.drive_busy[w[5:4]] = 1'b1;
            end
          end else begin
            s_next.bresp = floppy_ctl_pkg::RESP_SLVERR;
          end
        end
        default: s_next.bresp = floppy_ctl_pkg::RESP_SLVERR;
      endcase
    end
    if (arvalid_in && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = floppy_ctl_pkg::RESP_OKAY;
      case (araddr_in)
        floppy_ctl_pkg::OFF_SPEC: s_next.rdata = {16'h0000, s_reg.spec};
        floppy_ctl_pkg::OFF_CONF: s_next.rdata = {13'h0000, s_reg.conf};
        floppy_ctl_pkg::OFF_RESULT: begin
          s_next.rdata = {s_reg.st3, 7'h00, s_reg.ma, s_reg.present_cylinder, s_reg.st0};
        end
        floppy_ctl_pkg::OFF_STATUS: begin
          s_next.rdata = {23'h00_0000, request_for_master_out, s_reg.drive_busy,
                          1'b0, s_reg.fsm != ST_IDLE, s_reg.intr, s_reg.busy};
        end
        floppy_ctl_pkg::OFF_ID: s_next.rdata = s_reg.id_field;
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = floppy_ctl_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.poll_pending && s_reg.fsm == ST_IDLE && !s_reg.intr) begin
      s_next.poll_pending = 1'b0;
      if (!s_reg.conf[2] && !hut_run) begin
        s_next.intr = 1'b1;
        s_next.st0 = make_st0(floppy_ctl_pkg::IC_POLL, 1'b0, 1'b0, s_reg.drv);
      end else if (hut_run && !s_reg.conf[2]) begin
        s_next.poll_pending = 1'b1;
      end
    end
    if (result_entry_in) begin
      s_next.intr = 1'b1;
    end
    case (s_reg.fsm)
      ST_IDLE: s_next.step = 1'b0;
      ST_CMD: begin
        s_next.busy = 1'b0;
        s_next.steps = 7'h00;
        s_next.idx_cnt = 2'h0;
        if (s_reg.op == floppy_ctl_pkg::OP_READ_ID) begin
          s_next.fsm = ST_READ_ID;
        end else begin
          if (s_reg.op == floppy_ctl_pkg::OP_RECAL) begin
            s_next.present_cylinder = 8'h00;
          end
          s_next.fsm = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (s_reg.op == floppy_ctl_pkg::OP_RECAL) begin
          s_next.step_way = 1'b0;
          if (track_zero_in) begin
            s_next.fsm = ST_IDLE;
            s_next.intr = 1'b1;
            s_next.st0 = make_st0(floppy_ctl_pkg::IC_NORMAL, 1'b1, 1'b0, s_reg.drv);
          end else if (s_reg.steps >= floppy_ctl_pkg::RECAL_MAX_STEPS) begin
            s_next.fsm = ST_IDLE;
            s_next.intr = 1'b1;
            s_next.st0 = make_st0(floppy_ctl_pkg::IC_ABNORMAL, 1'b1, 1'b1, s_reg.drv);
          end else begin
            s_next.fsm = ST_PULSE;
          end
        end else if (s_reg.present_cylinder == s_reg.new_cylinder) begin
          s_next.fsm = ST_IDLE;
          s_next.intr = 1'b1;
          s_next.st0 = make_st0(floppy_ctl_pkg::IC_NORMAL, 1'b1, 1'b0, s_reg.drv);
        end else begin
          s_next.step_way = s_reg.present_cylinder < s_reg.new_cylinder;
          s_next.fsm = ST_PULSE;
        end
      end
      ST_PULSE: begin
        s_next.step = 1'b1;
        s_next.steps = s_reg.steps + 7'h01;
        s_next.t_start = 1'b1;
        if (s_reg.op == floppy_ctl_pkg::OP_SEEK) begin
          s_next.present_cylinder = s_reg.step_way ? s_reg.present_cylinder + 8'h01 : s_reg.present_cylinder - 8'h01;
        end
        s_next.fsm = ST_WAIT;
      end
      ST_WAIT: begin
        s_next.step = 1'b0;
        if (step_done) begin
          s_next.fsm = ST_CHECK;
        end
      end
      ST_READ_ID: begin
        if (id_found_in) begin
          s_next.id_field = id_field_in;
          s_next.st0 = make_st0(floppy_ctl_pkg::IC_NORMAL, 1'b0, 1'b0, s_reg.drv);
          s_next.intr = 1'b1;
          s_next.fsm = ST_IDLE;
        end else if (idx_edge) begin
          s_next.idx_cnt = s_reg.idx_cnt + 2'h1;
          if (s_reg.idx_cnt == 2'h1) begin
            s_next.st0 = make_st0(floppy_ctl_pkg::IC_ABNORMAL, 1'b0, 1'b0, s_reg.drv);
            s_next.ma = 1'b1;
            s_next.intr = 1'b1;
            s_next.fsm = ST_IDLE;
          end
        end
      end
      default: s_next.fsm = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.conf[1] <= floppy_ctl_pkg::FIFO_DISABLE_RST;
      s_reg.conf[7:4] <= floppy_ctl_pkg::FIFO_LEVEL_RST;
      s_reg.conf[15:8] <= floppy_ctl_pkg::PRECOMP_RST;
      s_reg.poll_pending <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  drive_delay_timer step_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(s_reg.t_start),
    .units_in(9'(floppy_ctl_pkg::STEP_SPAN_UNITS - {5'h00, s_reg.spec[7:4]})),
    .unit_cycles_in(unit_cyc),
    .done_out(step_done),
    .running_out()
  );

  drive_delay_timer unload_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(rw_exec_end_in),
    .units_in(s_reg.spec[3:0] == 4'h0 ? floppy_ctl_pkg::FULL_UNITS :
              {1'b0, s_reg.spec[3:0], 4'h0}),
    .unit_cycles_in(unit_cyc),
    .done_out(),
    .running_out(hut_run)
  );

  drive_delay_timer load_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(head_load_in && !s_reg.load_prev),
    .units_in(s_reg.spec[14:8] == 7'h00 ? floppy_ctl_pkg::FULL_UNITS :
              {1'b0, s_reg.spec[14:8], 1'b0}),
    .unit_cycles_in(unit_cyc),
    .done_out(),
    .running_out(hlt_run)
  );

  assign awready_out = !s_reg.aw_ok && !s_reg.bvalid;
  assign wready_out = !s_reg.w_ok && !s_reg.bvalid;
  assign bvalid_out = s_reg.bvalid;
  assign bresp_out = s_reg.bresp;
  assign arready_out = !s_reg.rvalid;
  assign rvalid_out = s_reg.rvalid;
  assign rdata_out = s_reg.rdata;
  assign rresp_out = s_reg.rresp;
  assign step_out = s_reg.step;
  assign step_way_out = s_reg.step_way;
  assign request_for_master_out = s_reg.spec[15] && xfer_need_in;
  assign dma_request_out = !s_reg.spec[15] && xfer_need_in;
  assign interrupt_out = s_reg.intr || request_for_master_out;
  assign head_unloaded_out = !hut_run;
  assign head_ready_out = head_load_in && s_reg.load_prev && !hlt_run;
  assign implied_seek_enable_out = s_reg.conf[0];
  assign fifo_disable_out = s_reg.conf[1];
  assign fifo_threshold_out = s_reg.conf[1] ? 5'h01 : {1'b0, s_reg.conf[7:4]} + 5'h01;
  assign precomp_start_cylinder_out = s_reg.conf[15:8];

  ////////////////////////////////////////////////////////////////////////////

  chk_seek_way_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.fsm == ST_PULSE && s_reg.op == floppy_ctl_pkg::OP_SEEK)
    |-> s_reg.step_way == (s_reg.present_cylinder < s_reg.new_cylinder)) else $error("Seek stepped wrong way.");
  chk_recal_way_out: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.op == floppy_ctl_pkg::OP_RECAL && step_out) |-> !step_way_out)
    else $error("Recalibrate stepped inward.");
  chk_recal_step_limit: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.fsm == ST_CHECK && s_reg.op == floppy_ctl_pkg::OP_RECAL && !track_zero_in
     && s_reg.steps == floppy_ctl_pkg::RECAL_MAX_STEPS)
    |=> s_reg.fsm == ST_IDLE && s_reg.st0[5:4] == 2'b11 && s_reg.intr)
    else $error("Recalibrate fault not reported.");
  chk_busy_phase: assert property (@(posedge clk_in) disable iff (rst_in)
    s_reg.fsm == ST_CMD |=> !s_reg.busy [*2]) else $error("Busy held into execution.");
  chk_seek_end_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.fsm == ST_CHECK && s_reg.op == floppy_ctl_pkg::OP_SEEK && s_reg.present_cylinder == s_reg.new_cylinder)
    |=> s_reg.intr && s_reg.st0[7:4] == 4'h2 && s_reg.st0[2] == 1'b0)
    else $error("Seek end status wrong.");
  chk_pcn_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.fsm == ST_PULSE && s_reg.op == floppy_ctl_pkg::OP_SEEK && !powerdown_exit_in)
    |=> s_reg.present_cylinder == ($past(s_reg.step_way) ? $past(s_reg.present_cylinder) + 8'h01
                                             : $past(s_reg.present_cylinder) - 8'h01))
    else $error("Cylinder did not follow step.");
  chk_read_id_miss: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.fsm == ST_READ_ID && !id_found_in && idx_edge && s_reg.idx_cnt == 2'h1)
    |=> s_reg.ma && s_reg.st0[7:6] == floppy_ctl_pkg::IC_ABNORMAL && s_reg.fsm == ST_IDLE)
    else $error("Missing ID not reported.");
  chk_powerdown_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    powerdown_exit_in && s_reg.fsm == ST_IDLE |=> s_reg.present_cylinder == 8'h00)
    else $error("Cylinder kept over power-down exit.");
  chk_dma_exclusive: assert property (@(posedge clk_in) disable iff (rst_in)
    xfer_need_in |-> (request_for_master_out != dma_request_out) && interrupt_out
      == (s_reg.intr || s_reg.spec[15])) else $error("Transfer signalling wrong.");
  chk_sense_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid && s_reg.waddr == floppy_ctl_pkg::OFF_CMD
     && s_reg.wdata[3:0] == floppy_ctl_pkg::OP_SENSE_INT && s_reg.fsm == ST_IDLE
     && !result_entry_in && !s_reg.poll_pending)
    |=> !s_reg.intr) else $error("Sense interrupt did not clear.");
endmodule
`default_nettype wire

// ---- tb/floppy_drive_model.sv ----
// Behavioural drive: head position, track zero sensor and index pulses.
`timescale 1ns/10ps
`default_nettype none
module floppy_drive_model #(
  parameter int INDEX_PERIOD = 200
) (
  input wire logic clk_in,
  input wire logic step_in,
  input wire logic step_way_in,
  input wire logic stuck_in,
  output logic track_zero_out,
  output logic index_out
);
  int cyl = 0;
  int cnt = 0;
  always @(posedge clk_in) begin
    cnt <= (cnt == INDEX_PERIOD - 1) ? 0 : cnt + 1;
    if (step_in) begin
      cyl <= step_way_in ? cyl + 1 : ((cyl > 0) ? cyl - 1 : 0);
    end
  end
  // A stuck sensor never shows track zero, so the controller must give up by itself.
  assign track_zero_out = (cyl == 0) && !stuck_in;
  assign index_out = (cnt < 2);
endmodule
`default_nettype wire

// ---- tb/floppy_control_commands_tb.sv ----
// Self-checking bench of the floppy control-command unit.
`timescale 1ns/10ps
`default_nettype none
module floppy_control_commands_tb;
  localparam int UC = 4;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, drv_stat = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, id_field = 32'h0000_0000, rd, rdata;
  logic id_found = 1'b0, xfer = 1'b0, pd_exit = 1'b0, stuck = 1'b0, last_way = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, step, way, irq, request_for_master, dmarq, implied_seek_enable, fdis, tz, idx;
  logic [1:0] bresp, rresp, resp;
  logic rw_end = 1'b0, hload = 1'b0, res_ent = 1'b0, unl, hrdy;
  logic [4:0] thr;
  logic [7:0] pre;
  int error_cnt = 0, n_checks = 0, cyc = 0, n_steps = 0, gap = 0, since = 0;
  ////////////////////////////////////////////////////////////////////////////////
  floppy_control_commands #(.UNIT_CYCLES(UC)) i_dut (.clk_in, .rst_in,
    .awvalid_in(awvalid), .awready_out(awready), .awaddr_in(awaddr), .wvalid_in(wvalid),
    .wready_out(wready), .wdata_in(wdata), .wstrb_in(4'hf), .bvalid_out(bvalid),
    .bready_in(bready), .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready),
    .araddr_in(araddr), .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
    .rresp_out(rresp), .index_pulse_in(idx), .track_zero_in(tz), .id_found_in(id_found),
    .id_field_in(id_field), .drive_status_in(drv_stat), .result_entry_in(res_ent),
    .xfer_need_in(xfer), .rw_exec_end_in(rw_end), .head_load_in(hload),
    .powerdown_exit_in(pd_exit), .step_out(step), .step_way_out(way), .interrupt_out(irq),
    .request_for_master_out(request_for_master), .dma_request_out(dmarq), .head_unloaded_out(unl),
    .head_ready_out(hrdy), .implied_seek_enable_out(implied_seek_enable), .fifo_disable_out(fdis),
    .fifo_threshold_out(thr), .precomp_start_cylinder_out(pre));
  floppy_drive_model i_drive (.clk_in, .step_in(step), .step_way_in(way), .stuck_in(stuck),
    .track_zero_out(tz), .index_out(idx));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // Sampled on the falling edge so the registered step output has settled.
  always @(negedge clk_in) begin
    since <= since + 1;
    if (step === 1'b1) begin
      n_steps <= n_steps + 1;
      last_way <= way;
      gap <= since;
      since <= 1;
    end
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      $display("mismatch timeout expected %0d seen %0d", 0, cyc);
      error_cnt++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ap, wp, bp;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (bp) begin
      @(negedge clk_in);
      ap = ap && !awready;
      wp = wp && !wready;
      bp = !bvalid;
      resp = bresp;
      @(posedge clk_in);
      awvalid <= ap;
      wvalid <= wp;
      bready <= bp;
    end
  endtask
  task automatic rd_reg(input logic [7:0] a);
    logic ap, rp;
    ap = 1'b1;
    rp = 1'b1;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (rp) begin
      @(negedge clk_in);
      ap = ap && !arready;
      rp = !rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk_in);
      arvalid <= ap;
      rready <= rp;
    end
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] new_cylinder);
    wr(8'h00, {16'h0000, new_cylinder, 4'h0, op});
  endtask
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(negedge clk_in);
    @(posedge clk_in);
  endtask
  // Positioning command on drive 0, judged through steps, status and the sense result.
  task automatic run_pos(input logic [3:0] op, input logic [7:0] new_cylinder, input int n,
                         input logic w, input logic [7:0] st0, input int lim);
    int s0;
    s0 = n_steps;
    cmd(op, new_cylinder);
    rd_reg(8'h10);
    chk("busy", 0, rd[0]);
    chk("drive busy", 1, rd[4]);
    wait_irq(lim);
    chk("irq", 1, irq);
    chk("steps", n, n_steps - s0);
    chk("way", w, last_way);
    cmd(floppy_ctl_pkg::OP_SENSE_INT, 8'h00);
    rd_reg(8'h0c);
    chk("st0", st0, rd[7:0]);
    chk("pcn", new_cylinder, rd[15:8]);
    rd_reg(8'h10);
    chk("drive free", 0, rd[4]);
  endtask
  // Both head timers from one start edge, then a result-phase interrupt and its clearing.
  task automatic run_timers;
    int tu, tl;
    tu = 0;
    tl = 0;
    wr(8'h04, 32'h0000_02e1);
    rw_end <= 1'b1;
    hload <= 1'b1;
    @(posedge clk_in);
    rw_end <= 1'b0;
    repeat (100) begin
      @(negedge clk_in);
      tu += int'(unl === 1'b0);
      tl += int'(hrdy === 1'b0);
    end
    chk("unload time", 16 * UC, tu);
    chk("load time", 4 * UC, tl);
    @(posedge clk_in);
    hload <= 1'b0;
    res_ent <= 1'b1;
    @(posedge clk_in);
    res_ent <= 1'b0;
    @(negedge clk_in);
    chk("result irq", 1, irq);
    cmd(floppy_ctl_pkg::OP_SENSE_INT, 8'h00);
    chk("result irq off", 0, irq);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    wait_irq(20);
    chk("poll irq", 1, irq);
    chk("defaults", 32'h0000_2100, {implied_seek_enable, fdis, thr, pre});
    cmd(floppy_ctl_pkg::OP_SENSE_INT, 8'h00);
    rd_reg(8'h0c);
    chk("poll st0", 8'hc0, rd[7:0]);
    chk("irq off", 0, irq);
    wr(8'h08, 32'h0000_fff1);
    chk("config", 32'h0000_50ff, {implied_seek_enable, fdis, thr, pre});
    wr(8'h04, 32'h0000_01e0);
    run_pos(floppy_ctl_pkg::OP_SEEK, 8'h03, 3, 1'b1, 8'h20, 300);
    chk("gap 1M", 1, gap >= 2 * UC && gap <= 2 * UC + 4);
    pd_exit <= 1'b1;
    @(posedge clk_in);
    pd_exit <= 1'b0;
    rd_reg(8'h0c);
    chk("pd clear", 0, rd[15:0]);
    wr(8'h08, 32'h0004_0002);
    run_pos(floppy_ctl_pkg::OP_SEEK, 8'h02, 2, 1'b1, 8'h20, 600);
    chk("gap 250K", 1, gap >= 8 * UC && gap <= 8 * UC + 4);
    wr(8'h08, 32'h0000_0002);
    run_pos(floppy_ctl_pkg::OP_RECAL, 8'h00, 5, 1'b0, 8'h20, 600);
    stuck <= 1'b1;
    run_pos(floppy_ctl_pkg::OP_RECAL, 8'h00, 79, 1'b0, 8'h70, 3000);
    stuck <= 1'b0;
    cmd(floppy_ctl_pkg::OP_READ_ID, 8'h00);
    id_field <= 32'h1234_5678;
    id_found <= 1'b1;
    @(posedge clk_in);
    id_found <= 1'b0;
    wait_irq(50);
    chk("id irq", 1, irq);
    rd_reg(8'h14);
    chk("id", 32'h1234_5678, rd);
    cmd(floppy_ctl_pkg::OP_SENSE_INT, 8'h00);
    cmd(floppy_ctl_pkg::OP_READ_ID, 8'h00);
    wait_irq(700);
    rd_reg(8'h0c);
    chk("no id", 3'b011, {rd[7:6], rd[16]});
    cmd(floppy_ctl_pkg::OP_SENSE_INT, 8'h00);
    drv_stat <= 8'ha5;
    cmd(floppy_ctl_pkg::OP_SENSE_DRIVE, 8'h00);
    repeat (5) @(posedge clk_in);
    chk("sense drive irq", 0, irq);
    rd_reg(8'h0c);
    chk("st3", 8'ha5, rd[31:24]);
    run_timers();
    wr(8'h04, 32'h0000_81e0);
    xfer <= 1'b1;
    @(negedge clk_in);
    chk("non dma", 3'b101, {request_for_master, dmarq, irq});
    @(posedge clk_in);
    wr(8'h04, 32'h0000_01e0);
    @(negedge clk_in);
    chk("dma", 3'b010, {request_for_master, dmarq, irq});
    @(posedge clk_in);
    xfer <= 1'b0;
    rd_reg(8'h40);
    chk("unmapped", floppy_ctl_pkg::RESP_SLVERR, resp);
    wr(8'h0c, 32'h0000_0000);
    chk("ro write", floppy_ctl_pkg::RESP_SLVERR, resp);
    final_report();
  end
endmodule
`default_nettype wire
